// >>> rtl/vrts_top.sv
// Purpose: Over/under voltage, high and low voltage ride-through supervision
// Assumes: Front end gives per-channel magnitudes with a same-clock update strobe
// Notes:   Profile borderline is a single level input; profile points left out
//
// Implementation choices: the address map and the Wishbone slave port.
`default_nettype none
// Functional notes
// - Pickup by one, two or three phase vote
// - Dropout uses configurable ratio setting
// - Overvoltage releases at ratio, e.g. 97%
// - Undervoltage releases at ratio, e.g. 103%
// - Crossing starts delay; expiry drives trip
// - Phase-to-ground: flags map phases one-three
// - Phase-to-phase: flags map 12, 23, 31
// - High ride-through idle unless planned overvoltage
// - Planned element evaluates only when enabled
// - Fundamental or RMS basis per setting
// - Nominal is rating/root3 or rating by mode
// - Phase-to-phase inputs force phase-to-phase mode
// - Ride-through starts below dip start level
// - Ride-through ends above recovery level
// - Trip only below borderline unless reclose-aware, else ride through
// - Reclose-aware: trip below profile or reclose failures
// - Dip count at limit trips immediately
// - Bad recovery level becomes 103% start
module vrts_top #(
	parameter int VW = vrts_pkg::VW,
	parameter int CW = vrts_pkg::CW
) (
	input  wire logic          clk,
	input  wire logic          reset_n,
	input  wire logic          sample_sync_reset,
	input  wire logic          sample_strobe,
	input  wire logic [3*VW-1:0] fund_mag,
	input  wire logic [3*VW-1:0] rms_mag,
	input  wire logic [VW-1:0] profile_level,
	input  wire logic          reclose_failed,
	input  wire logic [31:0]   wb_adr_i,
	input  wire logic [31:0]   wb_dat_i,
	input  wire logic [3:0]    wb_sel_i,
	input  wire logic          wb_we_i,
	input  wire logic          wb_cyc_i,
	input  wire logic          wb_stb_i,
	output logic      [31:0]   wb_dat_o,
	output logic               wb_ack_o,
	output logic      [2:0]    phase_pickup_flag,
	output logic      [2:0]    phase_trip_flag,
	output logic               ov_trip,
	output logic               uv_trip,
	output logic               hv_trip,
	output logic               rt_trip,
	output logic               irq
);
	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	logic [31:0]       ctrl;
	logic [VW-1:0]     ov_thr;
	logic [VW-1:0]     uv_thr;
	logic [vrts_pkg::PMW-1:0] ov_ratio;
	logic [vrts_pkg::PMW-1:0] uv_ratio;
	logic [CW-1:0]     delay_cnt_set;
	logic [VW-1:0]     start_lvl;
	logic [VW-1:0]     recover_lvl;
	logic [7:0]        dip_limit;
	logic [vrts_pkg::IRQ_BITS-1:0] irq_st;
	logic [vrts_pkg::IRQ_BITS-1:0] irq_mask;
	logic [VW-1:0]     rating;
	logic              bus_req;
	logic              rd_status_clr;
	logic [7:0]        adr;
	logic [31:0]       rd_mux;

	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign adr = wb_adr_i[7:0];
	assign rd_status_clr = bus_req && !wb_we_i && adr == vrts_pkg::REG_IRQ_ST;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ctrl <= 32'h0;
			ov_thr <= '1;
			uv_thr <= '0;
			ov_ratio <= vrts_pkg::OV_RATIO_RST;
			uv_ratio <= vrts_pkg::UV_RATIO_RST;
			delay_cnt_set <= '0;
			start_lvl <= '0;
			recover_lvl <= '0;
			dip_limit <= 8'h0;
			irq_mask <= '0;
			rating <= '0;
		end
		else if (bus_req && wb_we_i && wb_sel_i == 4'hF)
		begin
			unique case (adr)
				vrts_pkg::REG_CTRL: ctrl <= wb_dat_i;
				vrts_pkg::REG_OV_THR: ov_thr <= wb_dat_i[VW-1:0];
				vrts_pkg::REG_UV_THR: uv_thr <= wb_dat_i[VW-1:0];
				vrts_pkg::REG_RATIO:
				begin
					ov_ratio <= wb_dat_i[10:0];
					uv_ratio <= wb_dat_i[26:16];
				end
				vrts_pkg::REG_DELAY: delay_cnt_set <= wb_dat_i[CW-1:0];
				vrts_pkg::REG_RT_LVL:
				begin
					start_lvl <= wb_dat_i[VW-1:0];
					recover_lvl <= wb_dat_i[31:16];
				end
				vrts_pkg::REG_RT_CFG: dip_limit <= wb_dat_i[7:0];
				vrts_pkg::REG_IRQ_MASK: irq_mask <= wb_dat_i[vrts_pkg::IRQ_BITS-1:0];
				vrts_pkg::REG_NOMINAL: rating <= wb_dat_i[VW-1:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Measurement basis and nominal reference
	// ----------------------------------------------------------------
	logic [3*VW-1:0] mag;
	logic            pp_mode;
	logic [VW+16:0]  scaled;
	logic [VW-1:0]   nominal;

	assign mag = ctrl[vrts_pkg::C_RMS] ? rms_mag : fund_mag;
	assign pp_mode = ctrl[vrts_pkg::C_CONN_PP] | ctrl[vrts_pkg::C_MODE_PP];
	assign scaled = rating * vrts_pkg::INV_SQRT3_Q16;
	assign nominal = pp_mode ? rating : scaled[VW+15:16];

	// ----------------------------------------------------------------
	// Comparators with ratio dropout
	// ----------------------------------------------------------------
	logic [VW+10:0] ov_drop_x;
	logic [VW+10:0] uv_drop_x;
	logic [2:0]     ov_raw;
	logic [2:0]     uv_raw;
	logic [2:0]     ov_ph;
	logic [2:0]     uv_ph;
	logic [1:0]     vote;

	assign vote = ctrl[vrts_pkg::C_VOTE_LO+1:vrts_pkg::C_VOTE_LO];
	assign ov_drop_x = ov_thr * ov_ratio;
	assign uv_drop_x = uv_thr * uv_ratio;

	function automatic logic vote_ok(input logic [2:0] v, input logic [1:0] m);
		logic [1:0] n;
		n = 2'(v[0]) + 2'(v[1]) + 2'(v[2]);
		unique case (m)
			vrts_pkg::VOTE_TWO: vote_ok = n >= 2'h2;
			vrts_pkg::VOTE_ALL: vote_ok = n == 2'h3;
			default: vote_ok = n != 2'h0;
		endcase
	endfunction

	// Hysteresis per phase; channel order already matches flags in both connection types
	generate
		for (genvar p = 0; p < 3; p++)
		begin : g_ph
			logic [VW-1:0]  v;
			logic [VW+10:0] vx;
			assign v = mag[p*VW +: VW];
			assign vx = v * vrts_pkg::PERMILLE;
			assign ov_raw[p] = ov_ph[p] ? (vx > ov_drop_x) : (v >= ov_thr);
			assign uv_raw[p] = uv_ph[p] ? (vx < uv_drop_x) : (v <= uv_thr);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Pickup and trip delays
	// ----------------------------------------------------------------
	logic          ov_act;
	logic          uv_act;
	logic          hv_act;
	logic [CW-1:0] ov_t;
	logic [CW-1:0] uv_t;
	logic [CW-1:0] hv_t;
	logic          ov_pu;
	logic          uv_pu;
	logic          hv_pu;

	assign ov_act = ctrl[vrts_pkg::C_OV_EN];
	assign uv_act = ctrl[vrts_pkg::C_UV_EN];
	assign hv_act = ctrl[vrts_pkg::C_HV_PLAN] && ctrl[vrts_pkg::C_HV_FN];
	assign ov_pu = vote_ok(ov_ph, vote);
	assign uv_pu = vote_ok(uv_ph, vote);
	assign hv_pu = hv_act && ov_pu;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ov_ph <= '0;
			uv_ph <= '0;
		end
		else if (sample_sync_reset)
		begin
			ov_ph <= '0;
			uv_ph <= '0;
		end
		else if (sample_strobe)
		begin
			ov_ph <= (ov_act || hv_act) ? ov_raw : 3'h0;
			uv_ph <= uv_act ? uv_raw : 3'h0;
		end
	end

	function automatic logic [CW-1:0] step(input logic pu, input logic [CW-1:0] t, input logic [CW-1:0] lim);
		step = !pu ? '0 : (t < lim) ? t + 1'b1 : t;
	endfunction

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ov_t <= '0;
			uv_t <= '0;
			hv_t <= '0;
			ov_trip <= 1'b0;
			uv_trip <= 1'b0;
			hv_trip <= 1'b0;
		end
		else if (sample_sync_reset)
		begin
			ov_t <= '0;
			uv_t <= '0;
			hv_t <= '0;
			ov_trip <= 1'b0;
			uv_trip <= 1'b0;
			hv_trip <= 1'b0;
		end
		else if (sample_strobe)
		begin
			ov_t <= step(ov_pu && ov_act, ov_t, delay_cnt_set);
			uv_t <= step(uv_pu && uv_act, uv_t, delay_cnt_set);
			hv_t <= step(hv_pu, hv_t, delay_cnt_set);
			ov_trip <= ov_pu && ov_act && ov_t >= delay_cnt_set;
			uv_trip <= uv_pu && uv_act && uv_t >= delay_cnt_set;
			hv_trip <= hv_pu && hv_t >= delay_cnt_set;
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			phase_pickup_flag <= '0;
			phase_trip_flag <= '0;
		end
		else
		begin
			// Flag n follows channel n: phase n or line pair n,n+1
			phase_pickup_flag <= ov_ph | uv_ph;
			phase_trip_flag <= (ov_trip || hv_trip ? ov_ph : 3'h0) | (uv_trip ? uv_ph : 3'h0);
		end
	end

	// ----------------------------------------------------------------
	// Low voltage ride-through
	// ----------------------------------------------------------------
	typedef enum logic [1:0] { VRTS_STANDBY = 2'b01, VRTS_SUPERVISE = 2'b10 } vrts_rt_t;
	vrts_rt_t        rt_state;
	logic [VW-1:0]   vmin;
	logic [VW+10:0]  rec_fb;
	logic [VW-1:0]   rec_eff;
	logic [7:0]      dips;

	assign vmin = (mag[VW-1:0] < mag[2*VW-1:VW]) ?
		((mag[VW-1:0] < mag[3*VW-1:2*VW]) ? mag[VW-1:0] : mag[3*VW-1:2*VW]) :
		((mag[2*VW-1:VW] < mag[3*VW-1:2*VW]) ? mag[2*VW-1:VW] : mag[3*VW-1:2*VW]);
	assign rec_fb = (start_lvl * vrts_pkg::RECOVER_FALLBACK) / vrts_pkg::PERMILLE;
	// Fallback wraps by width truncation; keep start below full scale / 1.03
	assign rec_eff = (recover_lvl > start_lvl) ? recover_lvl : rec_fb[VW-1:0];

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rt_state <= VRTS_STANDBY;
			dips <= 8'h0;
			rt_trip <= 1'b0;
		end
		else if (sample_sync_reset || !ctrl[vrts_pkg::C_RT_EN])
		begin
			rt_state <= VRTS_STANDBY;
			dips <= 8'h0;
			rt_trip <= 1'b0;
		end
		else if (sample_strobe)
		begin
			unique case (rt_state)
				VRTS_STANDBY:
				begin
					rt_trip <= 1'b0;
					if (vmin < start_lvl)
					begin
						rt_state <= VRTS_SUPERVISE;
						if (ctrl[vrts_pkg::C_RT_AR])
							dips <= dips + 8'h1;
					end
				end
				VRTS_SUPERVISE:
				begin
					if (vmin > rec_eff)
						rt_state <= VRTS_STANDBY;
					if (vmin < profile_level)
						rt_trip <= 1'b1;
					else if (ctrl[vrts_pkg::C_RT_AR] && (reclose_failed || (dip_limit != 8'h0 && dips >= dip_limit)))
						rt_trip <= 1'b1;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Interrupts and read port
	// ----------------------------------------------------------------
	logic [vrts_pkg::IRQ_BITS-1:0] ev;
	assign ev = {rt_trip, hv_trip, uv_trip, ov_trip};

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			irq_st <= '0;
			irq <= 1'b0;
		end
		else
		begin
			// Set wins over a same-cycle read clear so no event is lost
			irq_st <= (rd_status_clr ? '0 : irq_st) | ev;
			irq <= |(irq_st & irq_mask);
		end
	end

	always_comb
	begin
		unique case (adr)
			vrts_pkg::REG_CTRL: rd_mux = ctrl;
			vrts_pkg::REG_OV_THR: rd_mux = 32'(ov_thr);
			vrts_pkg::REG_UV_THR: rd_mux = 32'(uv_thr);
			vrts_pkg::REG_RATIO: rd_mux = {5'h0, uv_ratio, 5'h0, ov_ratio};
			vrts_pkg::REG_DELAY: rd_mux = 32'(delay_cnt_set);
			vrts_pkg::REG_RT_LVL: rd_mux = {recover_lvl, start_lvl};
			vrts_pkg::REG_RT_CFG: rd_mux = {16'h0, dips, dip_limit};
			vrts_pkg::REG_STATUS: rd_mux = {20'h0, rt_state == VRTS_SUPERVISE, rt_trip, hv_trip, uv_trip,
				ov_trip, ov_ph, uv_ph, 1'b0};
			vrts_pkg::REG_IRQ_ST: rd_mux = 32'(irq_st);
			vrts_pkg::REG_IRQ_MASK: rd_mux = 32'(irq_mask);
			vrts_pkg::REG_NOMINAL: rd_mux = {nominal, rating};
			default: rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end
		else
		begin
			wb_ack_o <= bus_req;
			wb_dat_o <= bus_req ? rd_mux : 32'h0;
		end
	end
endmodule
`default_nettype wire

// >>> shared/vrts_pkg.sv
// Purpose: Constants shared by the voltage ride-through supervisor
// Assumes: Voltages are unsigned magnitudes in a common scale
// Notes:   Ratios are in per-mille
`default_nettype none
package vrts_pkg;
	localparam int VW = 16;
	localparam int CW = 24;
	localparam int PMW = 11;
	localparam logic [PMW-1:0] PERMILLE = 11'h3E8;
	localparam logic [PMW-1:0] RECOVER_FALLBACK = 11'h406;
	localparam logic [PMW-1:0] OV_RATIO_RST = 11'h3CA;
	localparam logic [PMW-1:0] UV_RATIO_RST = 11'h406;
	// One over root three as 0.16 fraction
	localparam logic [16:0] INV_SQRT3_Q16 = 17'h093CD;
	localparam int Q16_SHIFT = 16;
	localparam int REG_W = 32;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_OV_THR = 8'h04;
	localparam logic [7:0] REG_UV_THR = 8'h08;
	localparam logic [7:0] REG_RATIO = 8'h0C;
	localparam logic [7:0] REG_DELAY = 8'h10;
	localparam logic [7:0] REG_RT_LVL = 8'h14;
	localparam logic [7:0] REG_RT_CFG = 8'h18;
	localparam logic [7:0] REG_STATUS = 8'h1C;
	localparam logic [7:0] REG_IRQ_ST = 8'h20;
	localparam logic [7:0] REG_IRQ_MASK = 8'h24;
	localparam logic [7:0] REG_NOMINAL = 8'h28;
	localparam logic [1:0] VOTE_ANY = 2'h0;
	localparam logic [1:0] VOTE_TWO = 2'h1;
	localparam logic [1:0] VOTE_ALL = 2'h2;
	// Control register fields
	localparam int C_OV_EN = 0;
	localparam int C_UV_EN = 1;
	localparam int C_HV_PLAN = 2;
	localparam int C_HV_FN = 3;
	localparam int C_RMS = 4;
	localparam int C_CONN_PP = 5;
	localparam int C_MODE_PP = 6;
	localparam int C_RT_EN = 7;
	localparam int C_RT_AR = 8;
	localparam int C_VOTE_LO = 9;
	localparam int IRQ_BITS = 4;
	localparam int I_OV = 0;
	localparam int I_UV = 1;
	localparam int I_HV = 2;
	localparam int I_RT = 3;
endpackage
`default_nettype wire

// >>> verif/vrts_top_bench.sv
// Purpose: Self-checking bench for vrts_top
// Assumes: Front end strobes every 8 cycles
// Notes:   Most results are checked on the output ports, the rest read back over the bus
`default_nettype none
module vrts_top_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk;
	logic        reset_n;
	logic        sync_rst;
	logic        strobe;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [7:0]  adr;
	logic [31:0] dat;
	logic [31:0] rdat;
	logic        ack;
	logic [47:0] fset;
	logic [47:0] rset;
	logic [47:0] fund;
	logic [47:0] rms;
	logic [47:0] w;
	logic [15:0] prof;
	logic [15:0] nom;
	logic [2:0]  pflag;
	logic [2:0]  tflag;
	logic        ov;
	logic        uv;
	logic        hv;
	logic        rt;
	logic        irq;
	logic        rcf;
	logic [31:0] exp_q[$];
	int          errors;
	int          total_checks;
	int          cycles;
	int          v;
	int          n;
	int          k;
	vrts_vt_model VT (.clk(clk), .reset_n(reset_n), .fund_set(fset), .rms_set(rset),
		.strobe(strobe), .fund_mag(fund), .rms_mag(rms));
	vrts_top DUT (.clk(clk), .reset_n(reset_n), .sample_sync_reset(sync_rst),
		.sample_strobe(strobe), .fund_mag(fund), .rms_mag(rms), .profile_level(prof),
		.reclose_failed(rcf), .wb_adr_i({24'h0, adr}), .wb_dat_i(dat), .wb_sel_i(4'hF),
		.wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
		.phase_pickup_flag(pflag), .phase_trip_flag(tflag), .ov_trip(ov), .uv_trip(uv),
		.hv_trip(hv), .rt_trip(rt), .irq(irq));
	// ----
	// Tasks
	// ----
	task chk(input logic [31:0] seen, input logic [31:0] want);
		total_checks++;
		if (seen !== want)
		begin
			errors++;
			$display("mismatch at %0t: seen %h want %h", $time, seen, want);
		end
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task bus(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr_en;
		adr <= a;
		dat <= d;
		do @(posedge clk);
		while (ack !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask
	task volts(input logic [47:0] f, input logic [47:0] r, input int s);
		@(posedge clk);
		fset <= f;
		rset <= r;
		repeat (s * 8) @(posedge clk);
	endtask
	task sreset;
		@(posedge clk);
		sync_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sync_rst <= 1'b0;
	endtask
	task hyst(input logic [31:0] c, input logic [7:0] a, input logic [47:0] bg,
		input logic [15:0] on, hold, off, input logic [31:0] st);
		wr(vrts_pkg::REG_CTRL, c);
		wr(a, 32'h3E8);
		volts(bg | on, bg | on, 6);
		rd(vrts_pkg::REG_STATUS, st);
		chk({ov, uv}, {st[7], st[8]});
		volts(bg | hold, bg | hold, 3);
		rd(vrts_pkg::REG_STATUS, st);
		volts(bg | off, bg | off, 3);
		rd(vrts_pkg::REG_STATUS, 32'h0);
		$display("test hysteresis done");
	endtask
	// ----
	// Monitor, clock, timeout
	// ----
	always @(posedge clk)
		if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
			chk(rdat, exp_q.pop_front());
	always @(posedge clk)
	begin
		cycles++;
		// Whole run needs well under a tenth of this
		if (cycles == 30000)
		begin
			errors++;
			close_out();
		end
	end
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// ----
	// Scenarios
	// ----
	initial
	begin
		{reset_n, sync_rst, cyc, stb, we, adr, dat, fset, rset, prof, rcf} = '0;
		{errors, total_checks, cycles} = '0;
		void'($urandom(32'hF26E));
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		rd(vrts_pkg::REG_CTRL, 32'h0);
		rd(vrts_pkg::REG_OV_THR, 32'h0000FFFF);
		rd(vrts_pkg::REG_RATIO, 32'h040603CA);
		wr(8'h3C, 32'hFFFFFFFF);
		rd(8'h3C, 32'h0);
		$display("test defaults done");
		wr(vrts_pkg::REG_DELAY, 32'h2);
		wr(vrts_pkg::REG_OV_THR, 32'h3E8);
		wr(vrts_pkg::REG_IRQ_MASK, 32'h1);
		for (v = 0; v < 3; v++)
			for (n = 1; n < 4; n++)
			begin
				sreset();
				wr(vrts_pkg::REG_CTRL, 32'h1 | (v << 9));
				for (k = 0; k < 3; k++)
					w[k*16 +: 16] = k < n ? 16'h3E9 + 16'($urandom % 300) : 16'($urandom % 900);
				volts(w, w, 6);
				chk(ov, n > v);
				chk(pflag, 32'h7 >> (3 - n));
				if (n > v)
					chk(tflag, 3'h7 >> (3 - n));
			end
		sreset();
		volts(48'h0, 48'h0, 1);
		chk(irq, 1'b1);
		rd(vrts_pkg::REG_IRQ_ST, 32'h1);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		$display("test vote done");
		hyst(32'h1, vrts_pkg::REG_OV_THR, 48'h01F401F40000, 16'h44C, 16'h3D4, 16'h3B6, 32'h90);
		hyst(32'h2, vrts_pkg::REG_UV_THR, 48'h044C044C0000, 16'h384, 16'h3FC, 16'h44C, 32'h102);
		wr(vrts_pkg::REG_RATIO, 32'h04060384);
		hyst(32'h1, vrts_pkg::REG_OV_THR, 48'h01F401F40000, 16'h44C, 16'h398, 16'h37A, 32'h90);
		wr(vrts_pkg::REG_NOMINAL, 32'h3C00);
		nom = 16'((32'h3C00 * 32'(vrts_pkg::INV_SQRT3_Q16)) >> vrts_pkg::Q16_SHIFT);
		wr(vrts_pkg::REG_CTRL, 32'h01);
		rd(vrts_pkg::REG_NOMINAL, {nom, 16'h3C00});
		wr(vrts_pkg::REG_CTRL, 32'h41);
		rd(vrts_pkg::REG_NOMINAL, 32'h3C003C00);
		wr(vrts_pkg::REG_CTRL, 32'h21);
		rd(vrts_pkg::REG_NOMINAL, 32'h3C003C00);
		sreset();
		wr(vrts_pkg::REG_CTRL, 32'h11);
		volts(48'h044C044C044C, 48'h01F401F401F4, 6);
		chk(ov, 1'b0);
		volts(48'h01F401F401F4, 48'h044C044C044C, 6);
		chk(ov, 1'b1);
		sreset();
		wr(vrts_pkg::REG_CTRL, 32'h21);
		volts(48'h044C01F401F4, 48'h044C01F401F4, 6);
		chk(tflag, 3'h4);
		$display("test basis done");
		volts(48'h0, 48'h0, 1);
		sreset();
		wr(vrts_pkg::REG_IRQ_MASK, 32'h0);
		rd(vrts_pkg::REG_IRQ_ST, 32'h3);
		for (k = 0; k < 3; k++)
		begin
			sreset();
			wr(vrts_pkg::REG_CTRL, 32'(k + 1) << 2);
			volts(48'h044C044C044C, 48'h044C044C044C, 6);
			chk(hv, k == 2);
		end
		chk(irq, 1'b0);
		rd(vrts_pkg::REG_IRQ_ST, 32'h4);
		$display("test high ride-through done");
		sreset();
		wr(vrts_pkg::REG_RT_LVL, 32'h03840320);
		wr(vrts_pkg::REG_CTRL, 32'h80);
		prof <= 16'h01F4;
		volts(48'h02BC02BC02BC, 48'h02BC02BC02BC, 3);
		rd(vrts_pkg::REG_STATUS, 32'h800);
		volts(48'h019001900190, 48'h019001900190, 3);
		rd(vrts_pkg::REG_STATUS, 32'hC00);
		chk(rt, 1'b1);
		volts(48'h03E803E803E8, 48'h03E803E803E8, 3);
		rd(vrts_pkg::REG_STATUS, 32'h0);
		wr(vrts_pkg::REG_RT_CFG, 32'h2);
		wr(vrts_pkg::REG_CTRL, 32'h180);
		for (k = 0; k < 2; k++)
		begin
			volts(48'h02BC02BC02BC, 48'h02BC02BC02BC, 3);
			rd(vrts_pkg::REG_STATUS, k == 1 ? 32'hC00 : 32'h800);
			volts(48'h03E803E803E8, 48'h03E803E803E8, 3);
		end
		rd(vrts_pkg::REG_RT_CFG, 32'h0202);
		wr(vrts_pkg::REG_RT_CFG, 32'h0);
		rcf <= 1'b1;
		volts(48'h02BC02BC02BC, 48'h02BC02BC02BC, 3);
		rd(vrts_pkg::REG_STATUS, 32'hC00);
		chk(rt, 1'b1);
		rcf <= 1'b0;
		volts(48'h03E803E803E8, 48'h03E803E803E8, 3);
		sreset();
		wr(vrts_pkg::REG_CTRL, 32'h80);
		wr(vrts_pkg::REG_RT_LVL, 32'h00000320);
		volts(48'h02BC02BC02BC, 48'h02BC02BC02BC, 3);
		volts(48'h032A032A032A, 48'h032A032A032A, 3);
		rd(vrts_pkg::REG_STATUS, 32'h800);
		volts(48'h035203520352, 48'h035203520352, 3);
		rd(vrts_pkg::REG_STATUS, 32'h0);
		$display("test low ride-through done");
		close_out();
	end
endmodule
`default_nettype wire

// >>> verif/vrts_top_chk.sv
// Purpose: Port assertions for vrts_top
// Assumes: One clock, reset_n async active low
// Notes:   Trips move only on strobe or sync reset; rt_trip also clears when the ride-through enable is cleared
`default_nettype none
module vrts_top_chk (
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic        sample_sync_reset,
	input wire logic        sample_strobe,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	input wire logic [2:0]  phase_pickup_flag,
	input wire logic [2:0]  phase_trip_flag,
	input wire logic        ov_trip,
	input wire logic        uv_trip,
	input wire logic        hv_trip,
	input wire logic        rt_trip
);
	// ----
	// Assertions
	// ----
	default clocking dc @(posedge clk); endclocking
	default disable iff (!reset_n);
	logic [3:0] trips;
	assign trips = {ov_trip, uv_trip, hv_trip, rt_trip};
	sequence s_taken;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_sync_hold;
		sample_sync_reset ##1 sample_sync_reset;
	endsequence
	a_ack_answer: assert property (s_taken |=> wb_ack_o)
		else $error("request not acknowledged next cycle");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("acknowledge longer than one cycle");
	a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside acknowledge");
	// Ctrl writes are kept away from live trips by the bench
	a_trip_strobe: assert property (!$past(sample_strobe) && !$past(sample_sync_reset) |-> $stable(trips))
		else $error("trip moved without a strobe");
	a_ov_pickup: assert property ($rose(ov_trip) |-> $past(phase_pickup_flag != 3'h0))
		else $error("overvoltage trip without pickup");
	a_uv_pickup: assert property ($rose(uv_trip) |-> $past(phase_pickup_flag != 3'h0))
		else $error("undervoltage trip without pickup");
	a_trip_flag: assert property ($rose(ov_trip | uv_trip) |-> ##[0:2] phase_trip_flag != 3'h0)
		else $error("trip without a phase trip flag");
	a_sync_clear: assert property (s_sync_hold |=> trips == 4'h0)
		else $error("sync reset left a trip set");
endmodule
bind vrts_top vrts_top_chk u_chk (
	.clk(clk), .reset_n(reset_n), .sample_sync_reset(sample_sync_reset),
	.sample_strobe(sample_strobe), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .phase_pickup_flag(phase_pickup_flag),
	.phase_trip_flag(phase_trip_flag), .ov_trip(ov_trip), .uv_trip(uv_trip),
	.hv_trip(hv_trip), .rt_trip(rt_trip)
);
`default_nettype wire

// >>> verif/vrts_vt_model.sv
// Purpose: Sampled voltage front end
// Assumes: One strobe every 8 cycles
// Notes:   Values move only with the strobe, as a sampler would
`default_nettype none
module vrts_vt_model (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic [47:0] fund_set,
	input  wire logic [47:0] rms_set,
	output logic             strobe,
	output logic      [47:0] fund_mag,
	output logic      [47:0] rms_mag
);
	logic [2:0] div;
	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
		begin
			div <= 3'h0;
			strobe <= 1'b0;
			fund_mag <= 48'h0;
			rms_mag <= 48'h0;
		end
		else
		begin
			div <= div + 3'h1;
			strobe <= div == 3'h7;
			if (div == 3'h7)
			begin
				fund_mag <= fund_set;
				rms_mag <= rms_set;
			end
		end
endmodule
`default_nettype wire
